// *** rtl/tcsp_defs.svh ***
/*
  Constants of the transceiver control serial port slave: addresses,
  command fields, config reset values and cycle counts.
  Assumes it is included by bare name from the block's files.
*/
`ifndef TCSP_DEFS_SVH
`define TCSP_DEFS_SVH

// slave addresses
`define TCSP_ADDR_INDIV 3'h2
`define TCSP_ADDR_BCAST 3'h7

// first command byte: [2:0] address, [3] read flag, [7:4] index
`define TCSP_FLD_READ 3
`define TCSP_IDX_CTRL0 4'h0
`define TCSP_IDX_CTRL1 4'h1
`define TCSP_IDX_CTRL2 4'h2
`define TCSP_IDX_RESET 4'hd
`define TCSP_IDX_EXT 4'hf

// config register reset values
`define TCSP_CTRL0_RST 5'h00
`define TCSP_CTRL1_RST 8'h00
`define TCSP_CTRL2_RST 4'h7

// control register 0 bit positions
`define TCSP_BIT_RX_DRIVE 1
`define TCSP_BIT_EMIT_EN 2
`define TCSP_BIT_ACK_PULSE 4

// extended read indexes and arbitrary identity values
`define TCSP_EIDX_MAKER 8'h00
`define TCSP_EIDX_DEVICE 8'h01
`define TCSP_EXT_MAKER 8'h5a
`define TCSP_EXT_DEVICE 8'hc0

// cycle counts in serial clock edges
`define TCSP_INIT_LAST 5'h1d
`define TCSP_TURN_LAST 3'h3
`define TCSP_DATA_LAST 4'h8

// level of the response start bit
`define TCSP_START_RSP 1'b0

`endif

// *** rtl/tcsp_pkg.sv ***
/*
  Types of the transceiver control serial port slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tcsp_pkg;

  // gray codes along init, idle, command, turnaround, response
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_IDLE = 3'h1,
    ST_CMD = 3'h3,
    ST_TURN = 3'h2,
    ST_RESP = 3'h6,
    ST_ACK = 3'h5
  } tcsp_state_t;

endpackage

// *** rtl/tcsp_sync.sv ***
/*
  Two flip-flop synchroniser for the pins that arrive from outside
  the system clock domain.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
module tcsp_sync (
  // system
  input wire logic clk,
  input wire logic rstn,
  // pins in, synchronised levels out
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  import tcsp_pkg::*;

  logic [2:0] meta_reg;

  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

// *** rtl/tcsp_regs.sv ***
/*
  Configuration store of the serial port slave: control registers
  0 to 2, the special reset command, and the read data selector.
  Assumes commit and reset pulses are one system clock long.
*/
`timescale 1ns/1ps
`include "tcsp_defs.svh"
module tcsp_regs (
  // system
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic commit,
  input wire logic reset_cmd,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [3:0] rd_idx,
  input wire logic [7:0] ext_idx,
  output logic [7:0] rd_data,
  // live configuration
  output logic [4:0] ctrl0
);
  import tcsp_pkg::*;

  logic [4:0] ctrl0_reg, ctrl0_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [3:0] ctrl2_reg, ctrl2_next;

  // a write lands only when its command phase has completed
  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (reset_cmd) begin
      ctrl0_next = `TCSP_CTRL0_RST;
      ctrl1_next = `TCSP_CTRL1_RST;
      ctrl2_next = `TCSP_CTRL2_RST;
    end else if (commit) begin
      if (wr_idx == `TCSP_IDX_CTRL0) ctrl0_next = wr_data[4:0];
      if (wr_idx == `TCSP_IDX_CTRL1) ctrl1_next = wr_data;
      if (wr_idx == `TCSP_IDX_CTRL2) ctrl2_next = wr_data[7:4];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_reg <= `TCSP_CTRL0_RST;
      ctrl1_reg <= `TCSP_CTRL1_RST;
      ctrl2_reg <= `TCSP_CTRL2_RST;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // unused bits and unknown indexes read as zero
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_idx)
      `TCSP_IDX_CTRL0: rd_data = {3'h0, ctrl0_reg};
      `TCSP_IDX_CTRL1: rd_data = ctrl1_reg;
      `TCSP_IDX_CTRL2: rd_data = {ctrl2_reg, 4'h0};
      `TCSP_IDX_EXT: begin
        if (ext_idx == `TCSP_EIDX_MAKER) rd_data = `TCSP_EXT_MAKER;
        if (ext_idx == `TCSP_EIDX_DEVICE) rd_data = `TCSP_EXT_DEVICE;
      end
      default: rd_data = 8'h00;
    endcase
  end

  assign ctrl0 = ctrl0_reg;

endmodule

// *** rtl/tcsp_top.sv ***
/*
  Slave end of the transceiver control serial port: power-up clocking
  count, command parsing, turnaround, response, acknowledge pulse,
  emitter gating and read pin drive.
  Assumes the serial clock and write line are pins from the controller,
  sampled by clk (250 MHz), far faster than the serial clock.
*/
`timescale 1ns/1ps
`include "tcsp_defs.svh"
// Summary of operation
// - idle: write line low, read line high
// - slave only; never starts a transaction
// - command always; response only for reads
// - response starts four clocks after command
// - bytes follow back to back
// - start bit then byte, LSB first
// - sample on rising edge; master shifts falling
// - read data changes on rising edge
// - write line passes to emitter when idle
// - block emitter first edge, release at end
// - photodiode disconnected during read response
// - addressed slave drives regardless of enable
// - unaddressed slave keeps read line floating
// - ack enable: disconnect, one-clock low pulse
// - end read on write line fall
// - write line high restarts power-up count
// - answer address 010 and broadcast 111
// - configuration applies after command completes
module tcsp_top (
  // system
  input wire logic clk,
  input wire logic rstn,
  // serial link from the controller
  input wire logic sclk,
  input wire logic write_data_line,
  // photodiode receiver path
  input wire logic optical_receive_line,
  // emitter drive
  output logic optical_transmit_line,
  // three-state read data pin
  output logic read_data_line_o,
  output logic read_data_line_oe
);
  import tcsp_pkg::*;

  logic sclk_s, wd_s, orx_s;
  logic sclk_d_reg, wd_d_reg;
  logic rise, wd_fall;
  tcsp_state_t st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic byte_reg, byte_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] eidx_reg, eidx_next;
  logic [7:0] dout_reg, dout_next;
  logic blk_reg, blk_next;
  logic addr_reg, addr_next;
  logic indiv_reg, indiv_next;
  logic otx_reg, otx_next;
  logic rd_reg, rd_next;
  logic oe_reg, oe_next;
  logic commit, rst_cmd, done;
  logic [7:0] byte_val;
  logic is_rd, hit_now, indiv_now;
  logic [7:0] rd_data;
  logic [4:0] ctrl0;
  logic rx_drive_en, emit_en, ack_pulse_enable;

  // pins cross into the clk domain before anything reads them
  tcsp_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({optical_receive_line, write_data_line, sclk}),
    .sync_out({orx_s, wd_s, sclk_s})
  );

  tcsp_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .commit(commit),
    .reset_cmd(rst_cmd),
    .wr_idx(cmd_reg[7:4]),
    .wr_data(sh_next),
    .rd_idx(cmd_reg[7:4]),
    .ext_idx(eidx_reg),
    .rd_data(rd_data),
    .ctrl0(ctrl0)
  );

  assign rx_drive_en = ctrl0[`TCSP_BIT_RX_DRIVE];
  assign emit_en = ctrl0[`TCSP_BIT_EMIT_EN];
  assign ack_pulse_enable = ctrl0[`TCSP_BIT_ACK_PULSE];

  // edges of the synchronised serial clock and write line
  assign rise = sclk_s & ~sclk_d_reg;
  assign wd_fall = ~wd_s & wd_d_reg;
  assign byte_val = {wd_s, sh_reg[7:1]};

  // decode of the byte in flight; second byte reuses stored first
  always_comb begin
    is_rd = byte_reg ? cmd_reg[`TCSP_FLD_READ] : byte_val[`TCSP_FLD_READ];
    hit_now = addr_reg;
    indiv_now = indiv_reg;
    if (!byte_reg) begin
      indiv_now = byte_val[2:0] == `TCSP_ADDR_INDIV;
      hit_now = indiv_now | (byte_val[2:0] == `TCSP_ADDR_BCAST);
    end
  end

  // protocol sequencer; every step but the power-up restart and the read end on a write
  // line fall waits for a serial clock edge, so a stopped clock freezes the rest
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    sh_next = sh_reg;
    cmd_next = cmd_reg;
    eidx_next = eidx_reg;
    dout_next = dout_reg;
    blk_next = blk_reg;
    addr_next = addr_reg;
    indiv_next = indiv_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    commit = 1'b0;
    rst_cmd = 1'b0;
    done = 1'b0;
    unique case (st_reg)
      ST_INIT: begin
        if (wd_s) begin
          cnt_next = 5'h00;
        end else if (rise) begin
          if (cnt_reg == `TCSP_INIT_LAST) begin
            st_next = ST_IDLE;
            cnt_next = 5'h00;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      // a rising edge in ack ends the pulse and is also the next start
      // bit, so it must open the command rather than be swallowed
      ST_IDLE, ST_ACK: begin
        // only the controller's clock starts a transaction
        if (rise) begin
          st_next = ST_CMD;
          blk_next = 1'b1;
          bit_next = 4'h1;
          byte_next = 1'b0;
        end
      end
      ST_CMD: begin
        if (rise) begin
          if (bit_reg == 4'h0) begin
            bit_next = 4'h1; // start bit of the next byte
          end else begin
            sh_next = byte_val;
            if (bit_reg != `TCSP_DATA_LAST) begin
              bit_next = bit_reg + 4'h1;
            end else begin
              bit_next = 4'h0;
              if (!byte_reg) begin
                cmd_next = byte_val;
                addr_next = hit_now;
                indiv_next = indiv_now;
                if (is_rd) begin
                  byte_next = byte_val[7:4] == `TCSP_IDX_EXT;
                  done = byte_val[7:4] != `TCSP_IDX_EXT;
                end else begin
                  byte_next = byte_val[7:4] != `TCSP_IDX_RESET;
                  done = byte_val[7:4] == `TCSP_IDX_RESET;
                  rst_cmd = done & hit_now;
                end
              end else begin
                eidx_next = byte_val;
                done = 1'b1;
                commit = ~is_rd & hit_now;
              end
            end
          end
        end
        if (done) begin
          blk_next = 1'b0;
          if (is_rd) begin
            st_next = ST_TURN;
            cnt_next = 5'h00;
          end else if (hit_now & indiv_now & ack_pulse_enable &
              rx_drive_en) begin
            st_next = ST_ACK;
            rd_next = 1'b0;
            oe_next = 1'b1;
          end else begin
            st_next = ST_IDLE;
          end
        end
      end
      ST_TURN: begin
        if (wd_fall) begin
          st_next = ST_IDLE;
        end else if (rise) begin
          if (cnt_reg[2:0] == `TCSP_TURN_LAST) begin
            st_next = ST_RESP;
            bit_next = 4'h0;
            dout_next = rd_data;
            rd_next = `TCSP_START_RSP;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      ST_RESP: begin
        // watching the write line tolerates any response length
        if (wd_fall) begin
          st_next = ST_IDLE;
        end else if (rise && bit_reg != `TCSP_DATA_LAST) begin
          rd_next = dout_reg[0];
          dout_next = {1'b0, dout_reg[7:1]};
          bit_next = bit_reg + 4'h1;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // read pin: response owned by the addressed slave, ack state keeps its pulse, else receiver, or high with ack enabled
    if (st_next == ST_TURN || st_next == ST_RESP) begin
      oe_next = addr_next;
      if (st_next == ST_TURN) rd_next = 1'b1;
    end else if (st_next != ST_ACK) begin
      oe_next = rx_drive_en;
      rd_next = ack_pulse_enable | orx_s;
    end
  end

  // emitter follows the write line unless a command blocks it
  assign otx_next = wd_s & emit_en & ~blk_next;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      wd_d_reg <= 1'b0;
      st_reg <= ST_INIT;
      cnt_reg <= 5'h00;
      bit_reg <= 4'h0;
      byte_reg <= 1'b0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      eidx_reg <= 8'h00;
      dout_reg <= 8'h00;
      blk_reg <= 1'b0;
      addr_reg <= 1'b0;
      indiv_reg <= 1'b0;
      otx_reg <= 1'b0;
      rd_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      wd_d_reg <= wd_s;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      sh_reg <= sh_next;
      cmd_reg <= cmd_next;
      eidx_reg <= eidx_next;
      dout_reg <= dout_next;
      blk_reg <= blk_next;
      addr_reg <= addr_next;
      indiv_reg <= indiv_next;
      otx_reg <= otx_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
    end
  end

  assign optical_transmit_line = otx_reg;
  assign read_data_line_o = rd_reg;
  assign read_data_line_oe = oe_reg;

  // checks on the sequencer and pins
  no_start_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_IDLE && !rise |=> st_reg == ST_IDLE && !blk_reg)
    else $error("slave left idle without a clock edge");

  led_block_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_IDLE && rise |=> blk_reg && !optical_transmit_line)
    else $error("emitter not blocked at command start");

  led_pass_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_IDLE && !rise |=>
      optical_transmit_line == $past(wd_s & emit_en))
    else $error("emitter does not follow the write line");

  init_restart_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_INIT && wd_s |=> st_reg == ST_INIT && cnt_reg == 5'h00)
    else $error("power-up count not restarted");

  turn_start_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_TURN && cnt_reg == 5'h03 && rise && !wd_fall && addr_reg
      |=> st_reg == ST_RESP && !read_data_line_o && read_data_line_oe)
    else $error("response start bit not on fourth edge");

  rd_edge_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_RESP && $changed(read_data_line_o) |-> $past(rise))
    else $error("read data changed off a rising edge");

  foreign_float_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == ST_TURN || st_reg == ST_RESP) && !addr_reg
      |-> !read_data_line_oe)
    else $error("unaddressed slave drives the read line");

  resp_drive_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_RESP && addr_reg |-> read_data_line_oe)
    else $error("addressed slave not driving response");

  ack_pulse_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_ACK && !rise |=>
      st_reg == ST_ACK && read_data_line_oe && !read_data_line_o)
    else $error("acknowledge pulse cut short");

  read_end_a:
  assert property (@(posedge clk) disable iff (!rstn)
    st_reg == ST_RESP && wd_fall |=> st_reg == ST_IDLE)
    else $error("read not ended on write line fall");

  cfg_hold_a:
  assert property (@(posedge clk) disable iff (!rstn)
    !commit && !rst_cmd |=> $stable(ctrl0))
    else $error("configuration changed outside command end");

endmodule

// *** bench/tcsp_bfm_master.sv ***
/*
  Serial bus master model: drives the serial clock and the write line
  of the transceiver control port and samples the read line.
  Assumes clk is the bench system clock; every step lands on its
  falling edge, so the slave's synchronisers see clean levels.
*/
`timescale 1ns/1ps
module tcsp_bfm_master (
  // system
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic write_data_line,
  input wire logic read_data_line_o,
  input wire logic read_data_line_oe,
  // emitter watch
  input wire logic optical_transmit_line
);
  int half = 4; // four 4 ns cycles per half period: 32 ns serial clock
  int leaks = 0;
  logic pin;

  // the wire as the master sees it; pulled up when nobody drives
  assign pin = read_data_line_oe ? read_data_line_o : 1'b1;

  // idle bus: clock stopped, write line low
  initial begin
    sclk = 1'b0;
    write_data_line = 1'b0;
  end

  // one serial clock; the pin is sampled just before the rise
  task automatic tick(output logic smp, input bit chk);
    repeat (half) @(negedge clk);
    smp = pin;
    sclk = 1'b1;
    repeat (half) @(negedge clk);
    if (chk && optical_transmit_line !== 1'b0) leaks++;
    sclk = 1'b0;
  endtask

  // power-up clocking with the write line low
  task automatic clocks(input int n);
    logic s;
    write_data_line = 1'b0;
    repeat (n) tick(s, 1'b0);
  endtask

  // one transaction; the write line only moves after a falling edge
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
    input int nb, input bit rd, output logic [8:0] rsp, output bit drove);
    logic [17:0] bits;
    logic s;
    int last;
    bits = {b1, 1'b0, b0, 1'b0};
    last = 9 * nb - 1;
    rsp = '0;
    drove = 1'b0;
    write_data_line = bits[0];
    for (int k = 0; k <= last; k++) begin
      tick(s, k >= 1 && k < last);
      write_data_line = (k < last) ? bits[k + 1] : rd;
    end
    // response: start bit is due on the fourth edge after the command
    if (rd) begin
      for (int k = 0; k < 12; k++) begin
        tick(s, 1'b0);
        if (k >= 4) rsp[k - 4] = s;
        drove |= read_data_line_oe;
      end
      repeat (half) @(negedge clk);
      rsp[8] = pin;
      write_data_line = 1'b0;
    end
    repeat (2 * half) @(negedge clk);
  endtask
endmodule

// *** bench/tb_tcsp_top.sv ***
/*
  Self-checking bench of the transceiver control serial port slave,
  with a behavioural model of its configuration store.
  Assumes the master model in tcsp_bfm_master.sv and the rtl files.
*/
`timescale 1ns/1ps
`include "tcsp_defs.svh"
module tb_tcsp_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, write_data_line, optical_receive_line = 1'b0;
  logic optical_transmit_line, read_data_line_o, read_data_line_oe;
  int errors = 0;
  int n_checks = 0;
  int seed = 49;
  bit rx_noise = 1'b1;
  logic [4:0] m_c0;
  logic [7:0] m_c1;
  logic [3:0] m_c2;
  logic [7:0] v;
  logic [2:0] a;
  logic [8:0] rsp;
  bit dr;

  // 250 MHz system clock
  always #2 clk = ~clk;

  // photodiode noise, so a leaking receiver path shows in responses
  always @(negedge clk) if (rx_noise) optical_receive_line = $random(seed);

  tcsp_top tcsp_top_inst (.clk(clk), .rstn(rstn), .sclk(sclk),
    .write_data_line(write_data_line),
    .optical_receive_line(optical_receive_line),
    .optical_transmit_line(optical_transmit_line),
    .read_data_line_o(read_data_line_o),
    .read_data_line_oe(read_data_line_oe));
  tcsp_bfm_master tcsp_bfm_master_inst (.clk(clk), .sclk(sclk),
    .write_data_line(write_data_line),
    .read_data_line_o(read_data_line_o),
    .read_data_line_oe(read_data_line_oe),
    .optical_transmit_line(optical_transmit_line));

  task automatic check(input string what, input logic [8:0] exp,
    input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic m_reset();
    m_c0 = `TCSP_CTRL0_RST;
    m_c1 = `TCSP_CTRL1_RST;
    m_c2 = `TCSP_CTRL2_RST;
  endtask

  function automatic bit hit(input logic [2:0] ad);
    return ad == `TCSP_ADDR_INDIV || ad == `TCSP_ADDR_BCAST;
  endfunction

  function automatic logic [7:0] m_rd(input logic [3:0] idx,
    input logic [7:0] ext);
    case (idx)
      4'h0: return {3'h0, m_c0};
      4'h1: return m_c1;
      4'h2: return {m_c2, 4'h0};
      4'hf: return ext == 8'h00 ? `TCSP_EXT_MAKER :
        ext == 8'h01 ? `TCSP_EXT_DEVICE : 8'h00;
      default: return 8'h00;
    endcase
  endfunction

  // write; the model changes only for our own or the broadcast address
  task automatic wr(input logic [2:0] ad, input logic [3:0] idx,
    input logic [7:0] d);
    int nb;
    nb = (idx == `TCSP_IDX_RESET) ? 1 : 2;
    tcsp_bfm_master_inst.xfer({idx, 1'b0, ad}, d, nb, 1'b0, rsp, dr);
    if (hit(ad)) begin
      case (idx)
        4'h0: m_c0 = d[4:0];
        4'h1: m_c1 = d;
        4'h2: m_c2 = d[7:4];
        4'hd: m_reset();
        default: ;
      endcase
    end
  endtask

  // read and compare with the model
  task automatic rdchk(input logic [2:0] ad, input logic [3:0] idx,
    input logic [7:0] ext);
    int nb;
    nb = (idx == `TCSP_IDX_EXT) ? 2 : 1;
    tcsp_bfm_master_inst.xfer({idx, 1'b1, ad}, ext, nb, 1'b1, rsp, dr);
    check("drive", {8'h0, hit(ad)}, {8'h0, dr});
    if (hit(ad)) begin
      check("start", 9'h0, {8'h0, rsp[0]});
      check("data", {1'b0, m_rd(idx, ext)}, {1'b0, rsp[8:1]});
    end
  endtask

  task automatic pin_chk(input string what, input logic [1:0] exp);
    repeat (6) @(negedge clk);
    check(what, {7'h0, exp}, {7'h0, read_data_line_oe, read_data_line_o});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    m_reset();
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    check("emitter", 9'h0, {8'h0, optical_transmit_line});
    check("enable", 9'h0, {8'h0, read_data_line_oe});
    // a high write line mid-count must restart the power-up count
    tcsp_bfm_master_inst.clocks(20);
    tcsp_bfm_master_inst.write_data_line = 1'b1;
    repeat (4) @(negedge clk);
    tcsp_bfm_master_inst.clocks(15);
    tcsp_bfm_master_inst.xfer(8'h2a, 8'h0, 1, 1'b1, rsp, dr);
    check("early drive", 9'h0, {8'h0, dr});
    tcsp_bfm_master_inst.clocks(30);
    $display("test power-up done");
    // own, broadcast and foreign addresses over the three registers
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      a = v[2:0] % 3'h6;
      if (a >= 3'h2) a = a + 3'h1;
      if (i / 3 == 0) a = 3'h2;
      if (i / 3 == 1) a = 3'h7;
      v = $random(seed);
      if (i % 3 == 0) v = v & 8'h0f;
      wr(a, 4'(i % 3), v);
      rdchk(a, 4'(i % 3), 8'h0);
      if (a != 3'h2) rdchk(3'h2, 4'(i % 3), 8'h0);
    end
    $display("test registers done");
    wr(3'h2, 4'h0, 8'h04);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      tcsp_bfm_master_inst.write_data_line = v[0];
      repeat (6) @(negedge clk);
      check("emitter", {8'h0, v[0]}, {8'h0, optical_transmit_line});
    end
    tcsp_bfm_master_inst.write_data_line = 1'b0;
    repeat (6) @(negedge clk);
    rdchk(3'h7, 4'h0, 8'h0);
    wr(3'h2, 4'h1, 8'hff);
    check("block", 9'h0, {1'b0, 8'(tcsp_bfm_master_inst.leaks)});
    $display("test emitter done");
    rx_noise = 1'b0;
    wr(3'h2, 4'h0, 8'h06);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      optical_receive_line = v[0];
      pin_chk("rx idle", {1'b1, v[0]});
    end
    rx_noise = 1'b1;
    rdchk(3'h2, 4'h0, 8'h0);
    $display("test receiver done");
    wr(3'h2, 4'h0, 8'h16);
    wr(3'h2, 4'h1, 8'h05);
    pin_chk("ack", 2'h2);
    rdchk(3'h2, 4'h1, 8'h0);
    rx_noise = 1'b0;
    optical_receive_line = 1'b0;
    pin_chk("ack idle", 2'h3);
    wr(3'h7, 4'h2, 8'h50);
    pin_chk("no ack", 2'h3);
    rx_noise = 1'b1;
    $display("test ack done");
    wr(3'h2, `TCSP_IDX_RESET, 8'h0);
    rdchk(3'h2, 4'h2, 8'h0);
    rdchk(3'h2, 4'h0, 8'h0);
    for (int i = 0; i < 3; i++) rdchk(i == 1 ? 3'h7 : 3'h2, 4'hf, 8'(i));
    $display("test reset and extended done");
    end_sim();
  end

  // watchdog: the tests need well under a fifth of this span
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
